//--- hw/rgw_defines.svh
// Functional notes
// - Twenty-stage counter advances at half oscillator rate
// - Period field selects one of four taps
// - Period field resets to zero, 2^14 periods
// - Selected tap overflow raises guard timeout
// - Timeout goes to CPU as non-maskable request
// - Timeout vector address is 0020H
// - Writing 4EH to command clears counter
// - Counter also cleared by reset and STOP
// - Enable bit resets to one
// - Disable needs enable cleared plus B1H write
// - Setting enable bit again re-enables guard
// - Counter runs right after reset release
// - Only STOP halts; counting resumes after warm-up
// - Keeps counting in light standby and RUN
`ifndef RGW_DEFINES_SVH
`define RGW_DEFINES_SVH

// Register byte offsets
`define RGW_MODE_OFS     8'h00
`define RGW_CMD_OFS      8'h04
`define RGW_STATUS_OFS   8'h08
`define RGW_ICLR_OFS     8'h0C
`define RGW_IEN_OFS      8'h10
`define RGW_COUNT_OFS    8'h14
`define RGW_VECTOR_OFS   8'h18

// Mode register fields and reset value
`define RGW_MODE_SEL_LSB 0
`define RGW_MODE_EN_BIT  2
`define RGW_MODE_RST     3'h4

// Command codes
`define RGW_CODE_CLEAR   8'h4E
`define RGW_CODE_DISABLE 8'hB1

// Counter shape: first tap bit and spacing between taps
`define RGW_CNT_W        20
`define RGW_TAP_BASE     13
`define RGW_TAP_STEP     2

// Interrupt vector handed to the CPU
`define RGW_VECTOR       16'h0020

`endif

//--- hw/rgw_pkg.sv
package rgw_pkg;
	// Guard run state
	typedef enum logic [1:0] {
		RGW_RUN,
		RGW_OFF,
		RGW_HALT
	} rgw_state_t;
	// Period selector
	typedef logic [1:0] rgw_sel_t;
endpackage

//--- hw/rgw_top.sv
// Implementation choices: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/1ps
`include "rgw_defines.svh"

module rgw_top (
	// Clock and reset
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// AHB-Lite slave
	input  wire logic        hsel,
	input  wire logic [7:0]  haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic [31:0]      hrdata,
	output logic             hresp,
	// Power manager pin: high while STOP or its warm-up lasts
	input  wire logic        stop_mode,
	// CPU side
	output logic             guard_timeout_irq,
	output logic [15:0]      nmi_vector,
	output logic             irq
);

	// Address phase capture
	logic                    a_valid_q;   // Data phase pending
	logic                    a_write_q;   // Pending is a write
	logic [7:0]              a_addr_q;    // Pending address
	// Software-visible state
	rgw_pkg::rgw_sel_t       detect_period_sel;
	logic                    guard_enable_bit;
	logic                    status_q;    // Sticky timeout flag
	logic                    ien_q;       // Interrupt enable
	// Engine
	rgw_pkg::rgw_state_t     state_q;
	logic                    div_q;       // Half-rate divider
	logic                    tick;        // One-cycle enable at fc/2
	logic [`RGW_CNT_W-1:0]   count_q;
	logic [3:0]              taps;
	logic                    tap_now;
	logic                    tap_q;
	logic                    tmo_evt;
	// Synchroniser for the STOP pin
	logic                    stop_m_q;    // First stage, read only by stop_s_q
	logic                    stop_s_q;
	// Decoded writes
	logic                    wr_mode;
	logic                    wr_cmd;
	logic                    wr_iclr;
	logic                    wr_ien;
	logic                    cmd_clear;
	logic                    cmd_disable;
	logic                    addr_take;

	assign addr_take   = hsel & htrans[1] & hready;
	assign wr_mode     = a_valid_q & a_write_q & (a_addr_q == `RGW_MODE_OFS);
	assign wr_cmd      = a_valid_q & a_write_q & (a_addr_q == `RGW_CMD_OFS);
	assign wr_iclr     = a_valid_q & a_write_q & (a_addr_q == `RGW_ICLR_OFS);
	assign wr_ien      = a_valid_q & a_write_q & (a_addr_q == `RGW_IEN_OFS);
	// Only the two codes have effect; any other byte falls through
	assign cmd_clear   = wr_cmd & (hwdata[7:0] == `RGW_CODE_CLEAR);
	assign cmd_disable = wr_cmd & (hwdata[7:0] == `RGW_CODE_DISABLE);

	// Two-stage synchroniser, the pin is asynchronous to hclk
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			stop_m_q <= 1'b0;
			stop_s_q <= 1'b0;
		end else begin
			stop_m_q <= stop_mode;
			stop_s_q <= stop_m_q;
		end
	end

	// Address phase register; zero wait states, so every phase is taken
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			a_valid_q <= 1'b0;
			a_write_q <= 1'b0;
			a_addr_q  <= 8'h00;
		end else if (hready) begin
			a_valid_q <= addr_take;
			a_write_q <= hwrite;
			a_addr_q  <= haddr;
		end
	end

	// Bus answer: not ready in reset, ready from the first edge after it, always OKAY
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hreadyout <= 1'b0;
			hresp     <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end
	end

	// Read data registered in the address phase; unmapped reads zero
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h0000_0000;
		end else if (addr_take && !hwrite) begin
			case (haddr)
				`RGW_MODE_OFS:   hrdata <= {29'h0, guard_enable_bit, detect_period_sel};
				`RGW_STATUS_OFS: hrdata <= {29'h0, state_q == rgw_pkg::RGW_OFF,
					state_q == rgw_pkg::RGW_RUN, status_q};
				`RGW_IEN_OFS:    hrdata <= {31'h0, ien_q};
				`RGW_COUNT_OFS:  hrdata <= {12'h000, count_q};
				`RGW_VECTOR_OFS: hrdata <= {16'h0000, `RGW_VECTOR};
				default:         hrdata <= 32'h0000_0000;
			endcase
		end
	end

	// Mode register; period resets to 2^14 and the guard starts armed
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			detect_period_sel <= 2'h0;
			guard_enable_bit  <= 1'b1;
		end else if (wr_mode) begin
			detect_period_sel <= hwdata[`RGW_MODE_SEL_LSB +: 2];
			guard_enable_bit  <= hwdata[`RGW_MODE_EN_BIT];
		end
	end

	// Run state: two-step disable resists a runaway program
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_q <= rgw_pkg::RGW_RUN;
		end else begin
			case (state_q)
				rgw_pkg::RGW_RUN: begin
					if (stop_s_q) begin
						state_q <= rgw_pkg::RGW_HALT;
					end else if (cmd_disable && !guard_enable_bit) begin
						state_q <= rgw_pkg::RGW_OFF;
					end
				end
				rgw_pkg::RGW_OFF: begin
					// Standby modes do not reach here; only software stops it
					if (wr_mode && hwdata[`RGW_MODE_EN_BIT]) begin
						state_q <= rgw_pkg::RGW_RUN;
					end
				end
				rgw_pkg::RGW_HALT: begin
					// Pin stays high through warm-up, so release means resume
					if (!stop_s_q) begin
						state_q <= rgw_pkg::RGW_RUN;
					end
				end
				default: state_q <= rgw_pkg::RGW_RUN;
			endcase
		end
	end

	// Half-rate enable from the oscillator clock
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			div_q <= 1'b0;
		end else begin
			div_q <= ~div_q;
		end
	end
	assign tick = div_q;

	// Binary counter; keeps running in light standby and RUN modes
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			count_q <= '0;
		end else if (cmd_clear || stop_s_q || state_q != rgw_pkg::RGW_RUN) begin
			count_q <= '0;
		end else if (tick) begin
			count_q <= count_q + 1'b1;
		end
	end

	// Tap outputs; the selector picks one of them
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_tap
			assign taps[gi] = count_q[`RGW_TAP_BASE + gi * `RGW_TAP_STEP];
		end
	endgenerate
	assign tap_now = taps[detect_period_sel];

	// Edge of the selected tap is the overflow
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tap_q <= 1'b0;
		end else begin
			tap_q <= tap_now;
		end
	end
	// Clear writes by software keep this from firing in normal use
	assign tmo_evt = tap_now & ~tap_q & (state_q == rgw_pkg::RGW_RUN);

	// Non-maskable request pulse and its vector
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			guard_timeout_irq <= 1'b0;
			nmi_vector        <= 16'h0000;
		end else begin
			guard_timeout_irq <= tmo_evt;
			nmi_vector        <= `RGW_VECTOR;
		end
	end

	// Sticky status; a new timeout beats a clear in the same cycle
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			status_q <= 1'b0;
		end else if (tmo_evt) begin
			status_q <= 1'b1;
		end else if (wr_iclr && hwdata[0]) begin
			status_q <= 1'b0;
		end
	end

	// Enable register and level interrupt
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ien_q <= 1'b0;
			irq   <= 1'b0;
		end else begin
			if (wr_ien) begin
				ien_q <= hwdata[0];
			end
			irq <= status_q & ien_q;
		end
	end

	// Divider alternates every cycle
	property p_tick_rate;
		@(posedge hclk) disable iff (!hresetn)
		tick |=> !tick ##1 tick;
	endproperty
	a_tick_rate: assert property (p_tick_rate) else $error("tick not half rate");

	// Counter advances only on a tick while running
	property p_count_adv;
		@(posedge hclk) disable iff (!hresetn)
		(tick && state_q == rgw_pkg::RGW_RUN && !cmd_clear && !stop_s_q)
			|=> count_q == $past(count_q) + 20'h00001;
	endproperty
	a_count_adv: assert property (p_count_adv) else $error("counter did not advance");

	// Clear code empties the counter
	property p_cmd_clear;
		@(posedge hclk) disable iff (!hresetn)
		cmd_clear |=> count_q == 20'h00000;
	endproperty
	a_cmd_clear: assert property (p_cmd_clear) else $error("clear code ignored");

	// Other codes leave run state alone
	property p_other_code;
		@(posedge hclk) disable iff (!hresetn)
		(wr_cmd && !cmd_disable && !stop_s_q && !wr_mode && state_q != rgw_pkg::RGW_HALT) |=> $stable(state_q);
	endproperty
	a_other_code: assert property (p_other_code) else $error("stray code acted");

	// Disable takes both steps
	property p_disable;
		@(posedge hclk) disable iff (!hresetn)
		(state_q == rgw_pkg::RGW_RUN && cmd_disable && !stop_s_q)
			|=> (state_q == rgw_pkg::RGW_OFF) == !$past(guard_enable_bit);
	endproperty
	a_disable: assert property (p_disable) else $error("disable sequence wrong");

	// Setting enable bit revives a disabled guard
	property p_reenable;
		@(posedge hclk) disable iff (!hresetn)
		(state_q == rgw_pkg::RGW_OFF && wr_mode && hwdata[`RGW_MODE_EN_BIT])
			|=> state_q == rgw_pkg::RGW_RUN && count_q == 20'h00000;
	endproperty
	a_reenable: assert property (p_reenable) else $error("re-enable failed");

	// Timeout reaches the CPU next cycle with vector
	property p_timeout_nmi;
		@(posedge hclk) disable iff (!hresetn)
		tmo_evt |=> guard_timeout_irq && nmi_vector == 16'h0020 ##1 status_q;
	endproperty
	a_timeout_nmi: assert property (p_timeout_nmi) else $error("timeout not delivered");

	// STOP halts and empties the counter
	property p_stop_halts;
		@(posedge hclk) disable iff (!hresetn)
		stop_s_q[*2] |=> count_q == 20'h00000 && !guard_timeout_irq;
	endproperty
	a_stop_halts: assert property (p_stop_halts) else $error("counting during STOP");

	// Disabled guard holds the counter empty and stays silent
	property p_off_quiet;
		@(posedge hclk) disable iff (!hresetn)
		state_q == rgw_pkg::RGW_OFF |=> count_q == 20'h00000 && !guard_timeout_irq;
	endproperty
	a_off_quiet: assert property (p_off_quiet) else $error("disabled guard counted");

	// Synchronised release of the STOP pin returns the guard to run next cycle
	property p_halt_resume;
		@(posedge hclk) disable iff (!hresetn)
		(state_q == rgw_pkg::RGW_HALT && !stop_s_q) |=> state_q == rgw_pkg::RGW_RUN;
	endproperty
	a_halt_resume: assert property (p_halt_resume) else $error("guard stuck after STOP");

endmodule // rgw_top

//--- tb/rgw_cpu_model.sv
`timescale 1ns/1ps

// Stand-in CPU core that takes each non-maskable request from the guard
module rgw_cpu_model (
	// Clock and reset
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// Request and vector from the guard
	input  wire logic        guard_timeout_irq,
	input  wire logic [15:0] nmi_vector,
	// Bookkeeping for the bench
	output int               nmi_count,
	output logic [15:0]      last_vector
);
	// No mask on this path: every high cycle is one taken request
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			nmi_count   <= 0;
			last_vector <= 16'h0000;
		end else if (guard_timeout_irq) begin
			nmi_count   <= nmi_count + 1;
			last_vector <= nmi_vector;
		end
	end
endmodule // rgw_cpu_model

//--- tb/runaway_watchdog_timer_bench.sv
`timescale 1ns/1ps
`include "rgw_defines.svh"

module runaway_watchdog_timer_bench;
	// Bus, pins and bookkeeping
	logic        hclk, hresetn, hsel, hwrite, stop_mode, hreadyout, hresp, guard_timeout_irq, irq;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [7:0]  haddr;
	logic [31:0] hwdata, hrdata, rd, c1;
	logic [15:0] nmi_vector, last_vector;
	int          err_total, check_count, nmi_count, n;
	wire logic   hready;

	// Single slave, so its ready is the bus ready
	assign hready = hreadyout;

	rgw_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
		.hrdata(hrdata), .hresp(hresp), .stop_mode(stop_mode), .guard_timeout_irq(guard_timeout_irq),
		.nmi_vector(nmi_vector), .irq(irq));

	rgw_cpu_model cpu (.hclk(hclk), .hresetn(hresetn), .guard_timeout_irq(guard_timeout_irq),
		.nmi_vector(nmi_vector), .nmi_count(nmi_count), .last_vector(last_vector));

	// Compare one value and count it
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			err_total++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// One single-word transfer; entered just after a rising edge
	task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
		hsel   <= 1'b1;
		haddr  <= a;
		hwrite <= wr;
		htrans <= 2'h2;
		do @(posedge hclk); while (hready !== 1'b1);
		hsel   <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hready !== 1'b1);
		rd = hrdata;
	endtask

	// Let a number of edges pass
	task automatic tick(input int k);
		repeat (k) @(posedge hclk);
	endtask

	// Verdict and end of run
	task automatic stop_test;
		$display("checks %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// 125 MHz clock
	initial begin
		hclk = 1'b0;
		forever #4 hclk = ~hclk;
	end

	// Cuts a hang short; the full run needs about 60600 cycles
	initial begin
		tick(80000);
		err_total++;
		$display("mismatch watchdog expired");
		stop_test();
	end

	// Main sequence
	initial begin
		{hresetn, hsel, hwrite, stop_mode, htrans, haddr, hwdata} = '0;
		hsize       = 3'h2;
		err_total   = 0;
		check_count = 0;
		tick(2);
		hresetn <= 1'b1;
		@(posedge hclk);
		xfer(1'b0, `RGW_MODE_OFS, 32'h0);
		chk("mode reset", rd, 32'h4);
		xfer(1'b0, `RGW_STATUS_OFS, 32'h0);
		chk("status reset", rd, 32'h2);
		xfer(1'b0, `RGW_VECTOR_OFS, 32'h0);
		chk("vector reg", rd, 32'h20);
		chk("vector pin", {16'h0, nmi_vector}, 32'h20);
		chk("bus answer", {30'h0, hreadyout, hresp}, 32'h2);
		xfer(1'b0, 8'h1C, 32'h0);
		chk("unmapped", rd, 32'h0);
		// Every period code; counter is still far below the lowest tap
		for (int i = 0; i < 4; i++) begin
			xfer(1'b1, `RGW_MODE_OFS, 32'h4 | i);
			xfer(1'b0, `RGW_MODE_OFS, 32'h0);
			chk("mode sel", rd, 32'h4 | i);
		end
		xfer(1'b1, `RGW_MODE_OFS, 32'h4);
		// A foreign command must not restart the count
		xfer(1'b0, `RGW_COUNT_OFS, 32'h0);
		c1 = rd;
		xfer(1'b1, `RGW_CMD_OFS, 32'h55);
		xfer(1'b0, `RGW_COUNT_OFS, 32'h0);
		chk("count grows", rd > c1, 32'h1);
		xfer(1'b1, `RGW_CMD_OFS, `RGW_CODE_CLEAR);
		xfer(1'b0, `RGW_COUNT_OFS, 32'h0);
		chk("count cleared", rd < 4, 32'h1);
		// Disable code alone is not enough while enabled
		xfer(1'b1, `RGW_CMD_OFS, `RGW_CODE_DISABLE);
		xfer(1'b0, `RGW_STATUS_OFS, 32'h0);
		chk("still running", rd, 32'h2);
		xfer(1'b1, `RGW_MODE_OFS, 32'h0);
		xfer(1'b1, `RGW_CMD_OFS, `RGW_CODE_DISABLE);
		xfer(1'b0, `RGW_STATUS_OFS, 32'h0);
		chk("disabled", rd, 32'h4);
		tick(40);
		xfer(1'b0, `RGW_COUNT_OFS, 32'h0);
		chk("held count", rd, 32'h0);
		xfer(1'b1, `RGW_MODE_OFS, 32'h4);
		tick(10);
		xfer(1'b0, `RGW_STATUS_OFS, 32'h0);
		chk("re-enabled", rd, 32'h2);
		// STOP clears and halts, release resumes
		stop_mode <= 1'b1;
		tick(6);
		xfer(1'b0, `RGW_COUNT_OFS, 32'h0);
		chk("stop count", rd, 32'h0);
		stop_mode <= 1'b0;
		tick(10);
		xfer(1'b0, `RGW_COUNT_OFS, 32'h0);
		chk("resumed", rd != 0, 32'h1);
		// Shortest period timeout with the interrupt masked
		xfer(1'b1, `RGW_IEN_OFS, 32'h0);
		xfer(1'b1, `RGW_CMD_OFS, `RGW_CODE_CLEAR);
		n = 0;
		while (guard_timeout_irq !== 1'b1 && n < 20000) begin
			@(posedge hclk);
			n++;
		end
		chk("timeout span", n >= 16380 && n <= 16390, 32'h1);
		@(posedge hclk);
		chk("pulse width", {31'h0, guard_timeout_irq}, 32'h0);
		tick(4);
		chk("nmi taken", nmi_count, 32'h1);
		chk("nmi vector", {16'h0, last_vector}, 32'h20);
		xfer(1'b0, `RGW_STATUS_OFS, 32'h0);
		chk("sticky", rd, 32'h3);
		chk("masked", {31'h0, irq}, 32'h0);
		xfer(1'b1, `RGW_IEN_OFS, 32'h1);
		tick(3);
		chk("irq on", {31'h0, irq}, 32'h1);
		xfer(1'b1, `RGW_ICLR_OFS, 32'h1);
		tick(3);
		chk("irq off", {31'h0, irq}, 32'h0);
		// Next tap up must not fire at the shortest span
		xfer(1'b1, `RGW_CMD_OFS, `RGW_CODE_CLEAR);
		xfer(1'b1, `RGW_MODE_OFS, 32'h5);
		tick(20000);
		chk("longer period", nmi_count, 32'h1);
		xfer(1'b1, `RGW_CMD_OFS, `RGW_CODE_CLEAR);
		xfer(1'b1, `RGW_MODE_OFS, 32'h4);
		// Regular servicing keeps the guard quiet
		repeat (2) begin
			tick(12000);
			xfer(1'b1, `RGW_CMD_OFS, `RGW_CODE_CLEAR);
		end
		tick(10);
		chk("serviced", nmi_count, 32'h1);
		// Mid-run reset of a disabled guard restores the armed defaults
		xfer(1'b1, `RGW_MODE_OFS, 32'h3);
		xfer(1'b1, `RGW_CMD_OFS, `RGW_CODE_DISABLE);
		hresetn <= 1'b0;
		tick(2);
		hresetn <= 1'b1;
		@(posedge hclk);
		xfer(1'b0, `RGW_MODE_OFS, 32'h0);
		chk("mode after reset", rd, 32'h4);
		xfer(1'b0, `RGW_STATUS_OFS, 32'h0);
		chk("status after reset", rd, 32'h2);
		stop_test();
	end
endmodule // runaway_watchdog_timer_bench
